// *** rtl/ipc_pkg.sv ***
// Functional notes
// - With tri-state enable clear (reset), the interrupt pin is always driven.
// - With tri-state enable set, the interrupt pin is driven only while active.
// - Polarity invert clear (reset) gives active-high, set gives active-low.
// - Drive select sets all non-I2C outputs: 0 low drive, 1 high drive.
// - The I2C clock and data outputs always keep high drive.
// - Pin loopback routes tx line 0 into rx line 0 and tx line 1 into rx 1.
// - Pin loopback makes replay, capture and source select ineffective.
// - Source select clear (reset) captures rx line 0, set captures rx line 1.
// - Capture stores the bits of the selected rx line into the tx buffer.
// - Capture overrides the rx line enables and rx interleave settings.
// - Replay sends captured data (or pattern if never captured) on both tx.
// - Pattern mode sends the default pattern on both tx lines, all channels.
package ipc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] PIN_BEHAVIOR_CONFIG_OFS      = 8'h52;
    localparam logic [7:0] SERIAL_PORT_TEST_CONTROL_OFS = 8'h53;
    localparam logic [7:0] PIN_BEHAVIOR_CONFIG_RST      = 8'h00;
    localparam logic [7:0] SERIAL_PORT_TEST_CONTROL_RST = 8'h00;

    // Writable bit masks, everything else is reserved
    localparam logic [7:0] PIN_BEHAVIOR_CONFIG_MASK      = 8'h31;
    localparam logic [7:0] SERIAL_PORT_TEST_CONTROL_MASK = 8'h1F;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int IRQ_TRISTATE_ENABLE_BIT = 5;
    localparam int IRQ_POLARITY_INVERT_BIT = 4;
    localparam int OUTPUT_DRIVE_SELECT_BIT = 0;

    localparam int PIN_LOOPBACK_ENABLE_BIT  = 4;
    localparam int LOOP_SOURCE_SELECT_BIT   = 3;
    localparam int CAPTURE_TO_TX_BUFFER_BIT = 2;
    localparam int REPLAY_TO_TX_ENABLE_BIT  = 1;
    localparam int PATTERN_TO_TX_ENABLE_BIT = 0;

    // ----------------------------------------------------------------
    // Test pattern and buffer sizing
    // ----------------------------------------------------------------
    localparam int          PATTERN_WIDTH   = 32;
    localparam logic [31:0] DEFAULT_PATTERN = 32'hA5A5_0F0F;
    localparam int          FRAME_BITS      = 512;
    localparam int          SYNC_STAGES     = 3;

endpackage

// *** rtl/ipc_frame_buf.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Transmit frame buffer used by capture and replay test modes
// ----------------------------------------------------------------
module ipc_frame_buf
    import ipc_pkg::*;
#(
    parameter int          DEPTH   = FRAME_BITS,
    parameter logic [31:0] PATTERN = DEFAULT_PATTERN
) (
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_bit_en,
    input  wire logic       i_frame_start,
    input  wire logic       i_wr_en,
    input  wire logic       i_wr_bit,
    input  wire logic [4:0] i_slot_bit,
    output logic            o_rd_bit
);

    localparam int AW = $clog2(DEPTH);

    logic [AW-1:0] idx_reg;
    logic          captured_reg;
    logic          mem [DEPTH];
    logic [4:0]    pat_idx;
    logic          rd_src;
    logic [AW-1:0] addr;

    // Frame start always lands on slot zero, for write and read alike
    assign addr    = i_frame_start ? '0 : idx_reg;
    // Pattern is sent MSB first within each channel slot
    assign pat_idx = 5'(PATTERN_WIDTH - 1) - i_slot_bit;
    // Never-captured buffer falls back to the pattern
    assign rd_src  = captured_reg ? mem[addr] : PATTERN[pat_idx];
    // Unregistered here; the tx pins add the only flip-flop stage
    assign o_rd_bit = rd_src;

    // ----------------------------------------------------------------
    // Bit index within the frame
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            idx_reg      <= '0;
            captured_reg <= 1'b0;
        end else if (i_bit_en) begin
            if (i_frame_start) begin
                // Slot zero is used by this strobe, next bit goes to one
                idx_reg <= AW'(1);
            end else if (idx_reg != AW'(DEPTH - 1)) begin
                idx_reg <= idx_reg + 1'b1;
            end
            if (i_wr_en) begin
                captured_reg <= 1'b1;
            end
        end
    end

    // Storage has no reset; the captured flag guards stale content
    always_ff @(posedge i_clk) begin
        if (i_bit_en && i_wr_en) begin
            mem[addr] <= i_wr_bit;
        end
    end

endmodule // ipc_frame_buf

// *** rtl/ipc_pin_test_ctrl.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Pin behaviour config and serial port test control
// ----------------------------------------------------------------
module ipc_pin_test_ctrl
    import ipc_pkg::*;
#(
    parameter int          DEPTH   = FRAME_BITS,
    parameter logic [31:0] PATTERN = DEFAULT_PATTERN
) (
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    // Register access port
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_wdata,
    output logic [7:0]      o_reg_rdata,
    output logic            o_reg_hit,
    // Interrupt pin
    input  wire logic       i_irq_active,
    output logic            o_irq_pin,
    output logic            o_irq_pin_oe,
    // Pad drive strength
    output logic            o_drive_high,
    output logic            o_i2c_drive_high,
    // Serial framing strobes
    input  wire logic       i_bit_en,
    input  wire logic       i_frame_start,
    input  wire logic [4:0] i_slot_bit,
    // Serial port configuration
    input  wire logic       i_rx_line0_enable,
    input  wire logic       i_rx_line1_enable,
    input  wire logic       i_rx_pin_interleave,
    input  wire logic       i_tx_line0_enable,
    input  wire logic       i_tx_line1_enable,
    input  wire logic       i_tx_pin_interleave,
    output logic            o_rx_line0_enable,
    output logic            o_rx_line1_enable,
    output logic            o_rx_pin_interleave,
    output logic            o_tx_line0_enable,
    output logic            o_tx_line1_enable,
    output logic            o_tx_pin_interleave,
    // Serial data
    input  wire logic       i_tx_data0,
    input  wire logic       i_tx_data1,
    input  wire logic       i_serial_rx_line0,
    input  wire logic       i_serial_rx_line1,
    output logic            o_serial_tx_line0,
    output logic            o_serial_tx_line1,
    output logic            o_rx_data0,
    output logic            o_rx_data1
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] pin_behavior_config_reg;
    logic [7:0] serial_port_test_control_reg;
    logic [7:0] rdata_next;
    logic       hit_cfg;
    logic       hit_test;

    assign hit_cfg  = (i_reg_addr == PIN_BEHAVIOR_CONFIG_OFS);
    assign hit_test = (i_reg_addr == SERIAL_PORT_TEST_CONTROL_OFS);

    // Unmapped reads return zero; reserved bits never stored
    assign rdata_next = hit_cfg  ? pin_behavior_config_reg :
                        hit_test ? serial_port_test_control_reg :
                                   8'h00;

    // Write path keeps only defined bits
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_behavior_config_reg      <= PIN_BEHAVIOR_CONFIG_RST;
            serial_port_test_control_reg <= SERIAL_PORT_TEST_CONTROL_RST;
        end else if (i_reg_wr) begin
            if (hit_cfg) begin
                pin_behavior_config_reg <=
                    i_reg_wdata & PIN_BEHAVIOR_CONFIG_MASK;
            end
            if (hit_test) begin
                serial_port_test_control_reg <=
                    i_reg_wdata & SERIAL_PORT_TEST_CONTROL_MASK;
            end
        end
    end

    // Read data captured on the read strobe
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_reg_rdata <= 8'h00;
            o_reg_hit   <= 1'b0;
        end else if (i_reg_rd) begin
            o_reg_rdata <= rdata_next;
            o_reg_hit   <= hit_cfg | hit_test;
        end
    end

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    logic irq_tristate_enable;
    logic irq_polarity_invert;
    logic output_drive_select;
    logic pin_loopback_enable;
    logic loop_source_select;
    logic capture_to_tx_buffer;
    logic replay_to_tx_enable;
    logic pattern_to_tx_enable;

    assign irq_tristate_enable =
        pin_behavior_config_reg[IRQ_TRISTATE_ENABLE_BIT];
    assign irq_polarity_invert =
        pin_behavior_config_reg[IRQ_POLARITY_INVERT_BIT];
    assign output_drive_select =
        pin_behavior_config_reg[OUTPUT_DRIVE_SELECT_BIT];
    assign pin_loopback_enable =
        serial_port_test_control_reg[PIN_LOOPBACK_ENABLE_BIT];
    assign pattern_to_tx_enable =
        serial_port_test_control_reg[PATTERN_TO_TX_ENABLE_BIT];

    // Loopback masks the buffer-related test bits
    assign loop_source_select = !pin_loopback_enable &&
        serial_port_test_control_reg[LOOP_SOURCE_SELECT_BIT];
    assign capture_to_tx_buffer = !pin_loopback_enable &&
        serial_port_test_control_reg[CAPTURE_TO_TX_BUFFER_BIT];
    assign replay_to_tx_enable = !pin_loopback_enable &&
        serial_port_test_control_reg[REPLAY_TO_TX_ENABLE_BIT];

    // ----------------------------------------------------------------
    // Interrupt pin and pad drive
    // ----------------------------------------------------------------
    // Combinational so the pin tracks the interrupt with no added lag
    assign o_irq_pin    = i_irq_active ^ irq_polarity_invert;
    assign o_irq_pin_oe = !irq_tristate_enable
                          || i_irq_active;
    assign o_drive_high     = output_drive_select;
    assign o_i2c_drive_high = 1'b1;

    // ----------------------------------------------------------------
    // Receive pin synchronisers
    // ----------------------------------------------------------------
    logic [SYNC_STAGES-1:0] rx0_sync_reg;
    logic [SYNC_STAGES-1:0] rx1_sync_reg;
    logic                   rx0_reg;
    logic                   rx1_reg;

    // Three stages; a level is accepted once stages two and three agree
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx0_sync_reg <= '0;
            rx1_sync_reg <= '0;
            rx0_reg      <= 1'b0;
            rx1_reg      <= 1'b0;
        end else begin
            rx0_sync_reg <= {rx0_sync_reg[SYNC_STAGES-2:0], i_serial_rx_line0};
            rx1_sync_reg <= {rx1_sync_reg[SYNC_STAGES-2:0], i_serial_rx_line1};
            if (rx0_sync_reg[1] == rx0_sync_reg[2]) begin
                rx0_reg <= rx0_sync_reg[2];
            end
            if (rx1_sync_reg[1] == rx1_sync_reg[2]) begin
                rx1_reg <= rx1_sync_reg[2];
            end
        end
    end

    // ----------------------------------------------------------------
    // Capture and replay buffer
    // ----------------------------------------------------------------
    logic capture_bit;
    logic buf_bit;

    assign capture_bit = loop_source_select ? rx1_reg : rx0_reg;

    ipc_frame_buf #(
        .DEPTH   (DEPTH),
        .PATTERN (PATTERN)
    ) u_frame_buf (
        .i_clk         (i_clk),
        .i_nrst        (i_nrst),
        .i_bit_en      (i_bit_en),
        .i_frame_start (i_frame_start),
        .i_wr_en       (capture_to_tx_buffer),
        .i_wr_bit      (capture_bit),
        .i_slot_bit    (i_slot_bit),
        .o_rd_bit      (buf_bit)
    );

    // ----------------------------------------------------------------
    // Transmit selection
    // ----------------------------------------------------------------
    logic [4:0] pat_idx;
    logic       pat_bit;
    logic       tx0_next;
    logic       tx1_next;
    logic       tx_forced;

    assign pat_idx   = 5'(PATTERN_WIDTH - 1) - i_slot_bit;
    assign pat_bit   = PATTERN[pat_idx];
    assign tx_forced = replay_to_tx_enable || pattern_to_tx_enable;

    // Replay outranks the plain pattern
    assign tx0_next = replay_to_tx_enable  ? buf_bit :
                      pattern_to_tx_enable ? pat_bit :
                                             i_tx_data0;
    assign tx1_next = replay_to_tx_enable  ? buf_bit :
                      pattern_to_tx_enable ? pat_bit :
                                             i_tx_data1;

    // Tx pins change only on the bit strobe
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_serial_tx_line0 <= 1'b0;
            o_serial_tx_line1 <= 1'b0;
        end else if (i_bit_en) begin
            o_serial_tx_line0 <= tx0_next;
            o_serial_tx_line1 <= tx1_next;
        end
    end

    // Replay and pattern modes force both lines on, no interleave
    assign o_tx_line0_enable   = tx_forced || i_tx_line0_enable;
    assign o_tx_line1_enable   = tx_forced || i_tx_line1_enable;
    assign o_tx_pin_interleave = !tx_forced && i_tx_pin_interleave;

    // Capture owns the receivers; normal settings are set aside
    assign o_rx_line0_enable   = !capture_to_tx_buffer
                                 && i_rx_line0_enable;
    assign o_rx_line1_enable   = !capture_to_tx_buffer
                                 && i_rx_line1_enable;
    assign o_rx_pin_interleave = !capture_to_tx_buffer
                                 && i_rx_pin_interleave;

    // ----------------------------------------------------------------
    // Receive data to the serial port, with pin loopback
    // ----------------------------------------------------------------
    assign o_rx_data0 = pin_loopback_enable ? o_serial_tx_line0
                                            : rx0_reg;
    assign o_rx_data1 = pin_loopback_enable ? o_serial_tx_line1
                                            : rx1_reg;

endmodule // ipc_pin_test_ctrl

// *** verification/ipc_sva.sv ***
`timescale 1ns/1ps
// ----------------
// Port checker
// ----------------
module ipc_sva
    import ipc_pkg::*;
#(
    parameter logic [31:0] PATTERN = DEFAULT_PATTERN
) (
    input wire logic       i_clk,
    input wire logic       i_nrst,
    input wire logic [7:0] i_reg_addr,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic       o_reg_hit,
    input wire logic       i_irq_active,
    input wire logic       o_irq_pin,
    input wire logic       o_irq_pin_oe,
    input wire logic       o_drive_high,
    input wire logic       o_i2c_drive_high,
    input wire logic       i_bit_en,
    input wire logic [4:0] i_slot_bit,
    input wire logic       i_rx_line0_enable,
    input wire logic       o_rx_line0_enable,
    input wire logic       o_tx_line0_enable,
    input wire logic       o_tx_pin_interleave,
    input wire logic       o_serial_tx_line0,
    input wire logic       o_serial_tx_line1,
    input wire logic       o_rx_data0
);
    logic [7:0] pbc_reg;
    logic [7:0] spt_reg;
    // Decode, and test bits as loopback leaves them
    wire       sel_p = i_reg_addr == 8'h52;
    wire       sel_s = i_reg_addr == 8'h53;
    wire       cap_w = spt_reg[2] & ~spt_reg[4];
    wire       rep_w = spt_reg[1] & ~spt_reg[4];
    wire [7:0] rd_w  = sel_p ? pbc_reg : (sel_s ? spt_reg : 8'h00);
    // Shadow copy, reserved bits never stored
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pbc_reg <= 8'h00;
            spt_reg <= 8'h00;
        end else begin
            if (i_reg_wr && sel_p) pbc_reg <= i_reg_wdata & 8'h31;
            if (i_reg_wr && sel_s) spt_reg <= i_reg_wdata & 8'h1f;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    property p_drv; !pbc_reg[5] |-> o_irq_pin_oe; endproperty
    a_drv: assert property (p_drv) else $error("irq pin released");
    property p_tri; pbc_reg[5] |-> o_irq_pin_oe == i_irq_active; endproperty
    a_tri: assert property (p_tri) else $error("irq enable wrong");
    property p_pol; o_irq_pin == (i_irq_active ^ pbc_reg[4]); endproperty
    a_pol: assert property (p_pol) else $error("irq level wrong");
    property p_str; o_drive_high == pbc_reg[0]; endproperty
    a_str: assert property (p_str) else $error("drive select wrong");
    property p_i2c; o_i2c_drive_high; endproperty
    a_i2c: assert property (p_i2c) else $error("i2c drive low");
    property p_lpb; spt_reg[4] |-> o_rx_data0 == o_serial_tx_line0; endproperty
    a_lpb: assert property (p_lpb) else $error("loopback wrong");
    property p_rxe; o_rx_line0_enable == (i_rx_line0_enable & ~cap_w); endproperty
    a_rxe: assert property (p_rxe) else $error("rx enable wrong");
    property p_txe; rep_w | spt_reg[0] |-> o_tx_line0_enable
        && !o_tx_pin_interleave; endproperty
    a_txe: assert property (p_txe) else $error("tx enable wrong");
    property p_pat; spt_reg[0] & ~rep_w & i_bit_en |=> o_serial_tx_line1
        == o_serial_tx_line0 && o_serial_tx_line0 == PATTERN[~$past(i_slot_bit)];
    endproperty
    a_pat: assert property (p_pat) else $error("pattern bit wrong");
    property p_rd; i_reg_rd |=> o_reg_rdata == $past(rd_w)
        && o_reg_hit == $past(sel_p | sel_s); endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");
endmodule // ipc_sva

// *** verification/ipc_serial_host.sv ***
`timescale 1ns/1ps
// ----------------
// Serial port host
// ----------------
module ipc_serial_host (
    input  wire logic        i_clk,
    input  wire logic        i_active,
    input  wire logic [4:0]  i_slot_bit,
    input  wire logic [31:0] i_word0,
    input  wire logic [31:0] i_word1,
    output logic             o_line0,
    output logic             o_line1
);
    logic toggle_reg = 1'b0;
    // Idle lines churn so a stale bit is never mistaken for data
    always_ff @(posedge i_clk) toggle_reg <= ~toggle_reg;
    // MSB first, bit chosen by slot so it settles well before the strobe
    assign o_line0 = i_active ? i_word0[~i_slot_bit] : toggle_reg;
    assign o_line1 = i_active ? i_word1[~i_slot_bit] : ~toggle_reg;
endmodule // ipc_serial_host

// *** verification/ipc_pin_test_ctrl_bench.sv ***
`timescale 1ns/1ps
// ----------------
// Bench top
// ----------------
module ipc_pin_test_ctrl_bench
    import ipc_pkg::*;
;
    localparam logic [31:0] PAT = 32'h5ac3_9617;
    localparam logic [31:0] WRD = 32'hc3a5_1e69;
    logic i_clk = '0, i_nrst = '0, i_reg_wr = '0, i_reg_rd = '0, host_on = '0;
    logic i_irq_active = '0, i_bit_en = '0, i_frame_start = '0;
    logic i_rx_line0_enable = '0, i_rx_line1_enable = '0;
    logic i_rx_pin_interleave = '0, i_tx_line0_enable = '0;
    logic i_tx_line1_enable = '0, i_tx_pin_interleave = '0;
    logic i_tx_data0 = '0, i_tx_data1 = '0, rd_d = '0, be_d = '0;
    logic [7:0] i_reg_addr = '0, i_reg_wdata = '0, o_reg_rdata;
    logic [4:0] i_slot_bit = '0;
    logic i_serial_rx_line0, i_serial_rx_line1, o_reg_hit, o_irq_pin;
    logic o_irq_pin_oe, o_drive_high, o_i2c_drive_high, o_rx_line0_enable;
    logic o_rx_line1_enable, o_rx_pin_interleave, o_tx_line0_enable;
    logic o_tx_line1_enable, o_tx_pin_interleave, o_serial_tx_line0;
    logic o_serial_tx_line1, o_rx_data0, o_rx_data1;
    logic [8:0] rd_q[$];
    logic [1:0] tx_q[$];
    int fails = 0, cmp_count = 0, cyc = 0;
    ipc_pin_test_ctrl #(.PATTERN(PAT)) dut (.*);
    ipc_serial_host host (.i_clk(i_clk), .i_active(host_on),
        .i_slot_bit(i_slot_bit), .i_word0(~WRD), .i_word1(WRD),
        .o_line0(i_serial_rx_line0), .o_line1(i_serial_rx_line1));
    always #2.5 i_clk = ~i_clk;
    task check(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        {i_reg_addr, i_reg_wdata, i_reg_wr} <= {a, d, 1'b1};
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [8:0] e);
        @(posedge i_clk);
        {i_reg_addr, i_reg_rd} <= {a, 1'b1};
        rd_q.push_back(e);
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
    endtask
    // One frame, a bit every 8 cycles so rx pins clear the synchroniser
    task frame(input int mode);
        logic [1:0] d;
        for (int k = 0; k < 32; k++) begin
            d = 2'($urandom);
            @(posedge i_clk);
            {i_slot_bit, host_on} <= {5'(k), 1'b1};
            repeat (6) @(posedge i_clk);
            {i_bit_en, i_frame_start, i_tx_data1, i_tx_data0} <= {1'b1, k == 0, d};
            {i_rx_line0_enable, i_rx_line1_enable, i_rx_pin_interleave,
                i_tx_line0_enable, i_tx_line1_enable,
                i_tx_pin_interleave} <= 6'($urandom);
            tx_q.push_back(mode == 0 ? d : {2{mode == 1 ? PAT[31-k] : WRD[31-k]}});
            @(posedge i_clk);
            {i_bit_en, i_frame_start} <= 2'b00;
        end
        host_on <= 1'b0;
        repeat (3) @(posedge i_clk);
        $display("frame test mode %0d done", mode);
    endtask
    // Results arrive a cycle after the strobe; oldest note is compared
    always @(posedge i_clk) begin
        rd_d <= i_reg_rd;
        be_d <= i_bit_en;
        if (rd_d) check({o_reg_hit, o_reg_rdata}, rd_q.pop_front());
        if (be_d) check({7'h00, o_serial_tx_line1, o_serial_tx_line0},
            {7'h00, tx_q.pop_front()});
        cyc++;
        if (cyc == 9000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        logic [7:0] r;
        void'($urandom(85371));
        repeat (6) @(posedge i_clk);
        i_nrst <= 1'b1;
        rd(8'h52, 9'h100);
        rd(8'h53, 9'h100);
        wr(8'h52, 8'hff);
        wr(8'h53, 8'he0);
        wr(8'h54, 8'hff);
        rd(8'h52, 9'h131);
        rd(8'h53, 9'h100);
        rd(8'h54, 9'h000);
        for (int m = 0; m < 8; m++) begin
            r = 8'($urandom);
            wr(8'h52, r);
            rd(8'h52, {1'b1, r & 8'h31});
        end
        $display("register test done");
        for (int m = 0; m < 16; m++) begin
            wr(8'h52, {2'b00, m[2], m[1], 3'b000, m[0]});
            i_irq_active <= m[3];
            @(posedge i_clk);
            #1;
            r = {4'h1, ~m[2] | m[3], m[3] ^ m[1], m[0]};
            check({5'h00, o_i2c_drive_high, o_irq_pin_oe, o_irq_pin, o_drive_high}, {1'b0, r});
        end
        $display("pin config test done");
        wr(8'h53, 8'h01);
        frame(1);
        wr(8'h53, 8'h02);
        frame(1);
        wr(8'h53, 8'h0c);
        frame(0);
        wr(8'h53, 8'h0a);
        frame(2);
        wr(8'h53, 8'h1e);
        frame(0);
        close_out();
    end
endmodule // ipc_pin_test_ctrl_bench
bind ipc_pin_test_ctrl ipc_sva #(.PATTERN(PATTERN)) u_sva (.*);
